// file: pkg/input_limit_map.svh
// Purpose: Offsets, field positions, reset values and scale constants of the limit bank.
// Assumes: Serial command codes are eight bits and registers are sixteen bits wide.
// Notes:   Definitions only.
`ifndef INPUT_LIMIT_MAP_SVH
`define INPUT_LIMIT_MAP_SVH

`define EFFECTIVE_LIMIT_OFFSET  8'h22
`define HW_PIN_CTRL_OFFSET      8'h31
`define HOST_LIMIT_OFFSET       8'h3F

`define HOST_LIMIT_RESET        16'h4000
`define EFFECTIVE_LIMIT_RESET   16'h0000
`define HW_PIN_CTRL_RESET       1'h0

`define CODE_MSB                14
`define CODE_LSB                8
`define RESERVED_BIT            15
`define HW_PIN_DISABLE_BIT      7

`define LIMIT_STEP_MA           13'h0032
`define LIMIT_OFFSET_MA         13'h0032

`define BITS_PER_BYTE           4'h8

`endif

// file: pkg/input_limit_pkg.sv
// Purpose: Types shared by the input current limit bank.
// Assumes: One clock domain.
// Notes:   Constants live in input_limit_map.svh.
package input_limit_pkg;

  typedef logic [6:0] limit_code_t;

  typedef enum logic [10:0] {
    BUS_IDLE     = 11'b000_0000_0001,
    BUS_ADDR     = 11'b000_0000_0010,
    BUS_ACK_ADDR = 11'b000_0000_0100,
    BUS_CMD      = 11'b000_0000_1000,
    BUS_ACK_CMD  = 11'b000_0001_0000,
    BUS_WLO      = 11'b000_0010_0000,
    BUS_ACK_WLO  = 11'b000_0100_0000,
    BUS_WHI      = 11'b000_1000_0000,
    BUS_ACK_WHI  = 11'b001_0000_0000,
    BUS_RD       = 11'b010_0000_0000,
    BUS_RD_ACK   = 11'b100_0000_0000
  } bus_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } bus_event_s;

endpackage : input_limit_pkg

// file: verilog/sync_2ff.sv
// Purpose: Two flip-flop synchroniser for pin levels.
// Assumes: Inputs are slow levels relative to core_clk.
// Notes:   The first stage feeds only the second stage; reset values follow pin idle levels.
`timescale 1ns/100ps
module sync_2ff #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_check
    $error("sync_2ff needs at least one bit");
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : sync_2ff

// file: verilog/limit_decode.sv
// Purpose: Turns a limit code into milliamps.
// Assumes: Weights are binary with a fixed step and a fixed offset.
// Notes:   Output is registered, one cycle after the code.
`timescale 1ns/100ps
`include "input_limit_map.svh"
module limit_decode #(
  parameter int CODE_W = 7,
  parameter int MA_W   = 13
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [CODE_W-1:0] code,
  output logic      [MA_W-1:0]   limit_ma
);

  logic [MA_W-1:0] ma_reg;
  logic [MA_W-1:0] ma_next;

  if (((2 ** CODE_W) + 1) * 50 >= (2 ** MA_W)) begin : g_check
    $error("limit_decode result width too small");
  end

  function automatic logic [MA_W-1:0] to_ma(input logic [CODE_W-1:0] c);
    to_ma = MA_W'(MA_W'(c) * MA_W'(`LIMIT_STEP_MA) + MA_W'(`LIMIT_OFFSET_MA)); // R2 R3 R4 R14
  endfunction : to_ma

  assign ma_next = to_ma(code);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ma_reg <= MA_W'(`LIMIT_OFFSET_MA);
    end else begin
      ma_reg <= ma_next;
    end
  end

  assign limit_ma = ma_reg;

endmodule : limit_decode

// file: verilog/input_current_limit_regs.sv
// Purpose: Input current limit register bank reached over the serial management bus.
// Assumes: Bus pins and analog comparator flags are asynchronous; current sample is on core_clk.
// Notes:   Word protocol, low byte first; the data pin is open drain.
// Operation
// R1 - Host writes one 16-bit word limit.
// R2 - Bits 14..8 weigh 3200 down to 50 mA.
// R3 - Fixed 50 mA offset added to code.
// R4 - Range 50 to 6400 mA, 50 mA steps.
// R5 - Host limit resets to bit 14 only.
// R6 - Adapter removal restores host default limit.
// R7 - Programmed value is a maximum current.
// R8 - Reserved bit 15 set is invalid write.
// R9 - Host bits 7..0 read zero, writes ignored.
// R10 - Control bit 7 of 0x31 disables pin.
// R11 - Pin above 4.0 V also disables it.
// R12 - Effective register reports applied limit source.
// R13 - Optimizer result lands in effective register.
// R14 - Effective register uses same offset encoding.
// R15 - Effective register at 0x22, resets zero.
// R16 - Over current or low voltage reduces charge.
// R17 - Effective register is read only, reserved zero.
// R18 - Invalid or read only writes change nothing.
`timescale 1ns/100ps
`include "input_limit_map.svh"
module input_current_limit_regs #(
  // Bus address of this device; the default value is arbitrary.
  parameter logic [6:0] DEV_ADDR = 7'h09
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        smb_clk_pin,
  input  wire logic        smb_data_in,
  output logic             smb_data_out,
  output logic             smb_data_oe,
  input  wire logic        adapter_present_pin,
  input  wire logic        hw_limit_pin_above_4v,
  input  wire logic        vin_below_setting_pin,
  input  wire logic [12:0] input_current_ma,
  input  wire logic        optimizer_done,
  input  wire logic [6:0]  optimizer_code,
  output logic      [6:0]  applied_limit_code,
  output logic      [12:0] applied_limit_ma,
  output logic             hw_limit_pin_enabled,
  output logic             reduce_charge,
  output logic             invalid_write
);

  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_check
    $error("DEV_ADDR lies in a reserved bus address range");
  end

  function automatic logic [15:0] read_word(input logic [7:0]  cmd,
                                            input logic [15:0] host,
                                            input logic [15:0] eff,
                                            input logic        pin_off);
    case (cmd)
      `HOST_LIMIT_OFFSET:      read_word = host;
      `EFFECTIVE_LIMIT_OFFSET: read_word = eff;
      `HW_PIN_CTRL_OFFSET:     read_word = {8'h00, pin_off, 7'h00};
      default:                 read_word = 16'h0000;
    endcase
  endfunction : read_word

  // Pin synchronisation and bus event detection.
  logic [4:0]                      pins_sync;
  logic                            scl_last_reg;
  logic                            sda_last_reg;
  logic                            adapter_last_reg;
  input_limit_pkg::bus_event_s     ev;
  logic                            scl_s;
  logic                            sda_s;
  logic                            adapter_s;
  logic                            pin_hi_s;
  logic                            vin_low_s;
  logic                            adapter_fall;

  // Bus pins reset to their idle high level so that no false edge follows reset.
  sync_2ff #(
    .WIDTH     (5),
    .RESET_VAL (5'h18)
  ) u_sync_2ff (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({smb_clk_pin, smb_data_in, adapter_present_pin,
                hw_limit_pin_above_4v, vin_below_setting_pin}),
    .sync_out (pins_sync)
  );

  assign scl_s        = pins_sync[4];
  assign sda_s        = pins_sync[3];
  assign adapter_s    = pins_sync[2];
  assign pin_hi_s     = pins_sync[1];
  assign vin_low_s    = pins_sync[0];
  assign ev.start     = scl_s & scl_last_reg & sda_last_reg & ~sda_s;
  assign ev.stop      = scl_s & scl_last_reg & ~sda_last_reg & sda_s;
  assign ev.rise      = scl_s & ~scl_last_reg;
  assign ev.fall      = ~scl_s & scl_last_reg;
  assign ev.sda       = sda_s;
  assign adapter_fall = adapter_last_reg & ~adapter_s;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_last_reg     <= 1'b1;
      sda_last_reg     <= 1'b1;
      adapter_last_reg <= 1'b0;
    end else begin
      scl_last_reg     <= scl_s;
      sda_last_reg     <= sda_s;
      adapter_last_reg <= adapter_s;
    end
  end

  // Bus protocol state.
  input_limit_pkg::bus_state_e state_reg;
  input_limit_pkg::bus_state_e state_next;
  logic [3:0]                  bit_cnt_reg;
  logic [3:0]                  bit_cnt_next;
  logic [7:0]                  shift_reg;
  logic [7:0]                  shift_next;
  logic [7:0]                  cmd_reg;
  logic [7:0]                  cmd_next;
  logic [7:0]                  low_reg;
  logic [7:0]                  low_next;
  logic                        rw_reg;
  logic                        rw_next;
  logic                        rd_hi_reg;
  logic                        rd_hi_next;
  logic                        nack_reg;
  logic                        nack_next;
  logic                        sda_oe_reg;
  logic                        sda_oe_next;
  logic                        byte_done;
  logic                        addr_match;
  logic                        wr_fire;
  logic [15:0]                 wr_word;
  logic [15:0]                 rd_word;
  logic [7:0]                  rd_byte;

  // Register bank state.
  logic [15:0]                 host_limit_reg;
  logic [15:0]                 effective_limit_reg;
  logic                        eff_valid_reg;
  logic                        pin_disable_reg;
  logic                        host_write;
  logic                        host_ok;
  logic                        ctrl_write;
  logic [6:0]                  applied_code;
  logic [6:0]                  applied_code_reg;
  logic                        hw_pin_en_reg;
  logic                        reduce_reg;
  logic                        invalid_reg;
  logic                        over_limit;

  assign byte_done  = (bit_cnt_reg == `BITS_PER_BYTE);
  assign addr_match = (shift_reg[7:1] == DEV_ADDR);
  assign wr_word    = {shift_reg, low_reg}; // R1
  assign wr_fire    = (state_reg == input_limit_pkg::BUS_WHI) & ev.fall & byte_done
                      & ~ev.start & ~ev.stop;
  assign rd_word    = read_word(cmd_reg, host_limit_reg, effective_limit_reg,
                                pin_disable_reg);
  assign rd_byte    = rd_hi_reg ? rd_word[7:0] : rd_word[15:8];

  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    cmd_next     = cmd_reg;
    low_next     = low_reg;
    rw_next      = rw_reg;
    rd_hi_next   = rd_hi_reg;
    nack_next    = nack_reg;
    sda_oe_next  = sda_oe_reg;
    if (ev.stop) begin
      state_next  = input_limit_pkg::BUS_IDLE;
      sda_oe_next = 1'b0;
    end else if (ev.start) begin
      state_next   = input_limit_pkg::BUS_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next  = 1'b0;
    end else begin
      case (state_reg)
        input_limit_pkg::BUS_ADDR, input_limit_pkg::BUS_CMD,
        input_limit_pkg::BUS_WLO, input_limit_pkg::BUS_WHI: begin
          if (ev.rise && !byte_done) begin
            shift_next   = {shift_reg[6:0], ev.sda};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (ev.fall && byte_done) begin
            sda_oe_next = 1'b1;
            case (state_reg)
              input_limit_pkg::BUS_ADDR: begin
                rw_next     = shift_reg[0];
                sda_oe_next = addr_match;
                state_next  = addr_match ? input_limit_pkg::BUS_ACK_ADDR
                                         : input_limit_pkg::BUS_IDLE;
              end
              input_limit_pkg::BUS_CMD: begin
                cmd_next   = shift_reg;
                state_next = input_limit_pkg::BUS_ACK_CMD;
              end
              input_limit_pkg::BUS_WLO: begin
                low_next   = shift_reg;
                state_next = input_limit_pkg::BUS_ACK_WLO;
              end
              default: begin
                state_next = input_limit_pkg::BUS_ACK_WHI;
              end
            endcase
          end
        end
        input_limit_pkg::BUS_ACK_ADDR: begin
          if (ev.fall) begin
            bit_cnt_next = 4'h0;
            if (rw_reg) begin
              shift_next  = rd_word[7:0];
              sda_oe_next = ~rd_word[7];
              rd_hi_next  = 1'b0;
              state_next  = input_limit_pkg::BUS_RD;
            end else begin
              sda_oe_next = 1'b0;
              state_next  = input_limit_pkg::BUS_CMD;
            end
          end
        end
        input_limit_pkg::BUS_ACK_CMD, input_limit_pkg::BUS_ACK_WLO: begin
          if (ev.fall) begin
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b0;
            state_next   = (state_reg == input_limit_pkg::BUS_ACK_CMD)
                           ? input_limit_pkg::BUS_WLO : input_limit_pkg::BUS_WHI;
          end
        end
        input_limit_pkg::BUS_ACK_WHI: begin
          if (ev.fall) begin
            sda_oe_next = 1'b0;
            state_next  = input_limit_pkg::BUS_IDLE;
          end
        end
        input_limit_pkg::BUS_RD: begin
          if (ev.fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_next = 1'b0;
              state_next  = input_limit_pkg::BUS_RD_ACK;
            end else begin
              shift_next   = {shift_reg[6:0], 1'b0};
              sda_oe_next  = ~shift_reg[6];
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        input_limit_pkg::BUS_RD_ACK: begin
          if (ev.rise) begin
            nack_next = ev.sda;
          end else if (ev.fall) begin
            if (nack_reg) begin
              state_next = input_limit_pkg::BUS_IDLE;
            end else begin
              shift_next   = rd_byte;
              sda_oe_next  = ~rd_byte[7];
              rd_hi_next   = ~rd_hi_reg;
              bit_cnt_next = 4'h0;
              state_next   = input_limit_pkg::BUS_RD;
            end
          end
        end
        input_limit_pkg::BUS_IDLE: begin
          sda_oe_next = 1'b0;
        end
        default: begin
          state_next  = input_limit_pkg::BUS_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg   <= input_limit_pkg::BUS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      low_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      rd_hi_reg   <= 1'b0;
      nack_reg    <= 1'b1;
      sda_oe_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      cmd_reg     <= cmd_next;
      low_reg     <= low_next;
      rw_reg      <= rw_next;
      rd_hi_reg   <= rd_hi_next;
      nack_reg    <= nack_next;
      sda_oe_reg  <= sda_oe_next;
    end
  end

  // Register writes; writes to the effective register are not decoded at all.
  assign host_write   = wr_fire & (cmd_reg == `HOST_LIMIT_OFFSET);
  assign host_ok      = host_write & ~wr_word[`RESERVED_BIT]; // R8 R18
  assign ctrl_write   = wr_fire & (cmd_reg == `HW_PIN_CTRL_OFFSET);
  assign applied_code = eff_valid_reg ? effective_limit_reg[`CODE_MSB:`CODE_LSB]
                                      : host_limit_reg[`CODE_MSB:`CODE_LSB]; // R12
  assign over_limit   = input_current_ma > applied_limit_ma; // R7

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      host_limit_reg      <= `HOST_LIMIT_RESET; // R5
      effective_limit_reg <= `EFFECTIVE_LIMIT_RESET; // R15
      eff_valid_reg       <= 1'b0;
      pin_disable_reg     <= `HW_PIN_CTRL_RESET;
    end else begin
      if (adapter_fall) begin
        host_limit_reg <= `HOST_LIMIT_RESET; // R6
      end else if (host_ok) begin
        host_limit_reg <= {1'b0, wr_word[`CODE_MSB:`CODE_LSB], 8'h00}; // R2 R9
      end
      if (optimizer_done) begin
        effective_limit_reg <= {1'b0, optimizer_code, 8'h00}; // R13 R17
        eff_valid_reg       <= 1'b1;
      end else if (adapter_fall) begin
        effective_limit_reg <= `HOST_LIMIT_RESET;
        eff_valid_reg       <= 1'b1;
      end else if (host_ok) begin
        effective_limit_reg <= {1'b0, wr_word[`CODE_MSB:`CODE_LSB], 8'h00}; // R12
        eff_valid_reg       <= 1'b1;
      end
      if (ctrl_write) begin
        pin_disable_reg <= wr_word[`HW_PIN_DISABLE_BIT]; // R10
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      applied_code_reg <= 7'h00;
      hw_pin_en_reg    <= 1'b0;
      reduce_reg       <= 1'b0;
      invalid_reg      <= 1'b0;
    end else begin
      applied_code_reg <= applied_code;
      hw_pin_en_reg    <= ~pin_disable_reg & ~pin_hi_s; // R10 R11
      reduce_reg       <= over_limit | vin_low_s; // R16
      invalid_reg      <= host_write & wr_word[`RESERVED_BIT]; // R8
    end
  end

  limit_decode #(
    .CODE_W (7),
    .MA_W   (13)
  ) u_limit_decode (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .code     (applied_code_reg),
    .limit_ma (applied_limit_ma)
  );

  assign smb_data_out         = 1'b0;
  assign smb_data_oe          = sda_oe_reg;
  assign applied_limit_code   = applied_code_reg;
  assign hw_limit_pin_enabled = hw_pin_en_reg;
  assign reduce_charge        = reduce_reg;
  assign invalid_write        = invalid_reg;

  // Checks.
  sequence s_host_word;
    host_ok && !adapter_fall;
  endsequence
  sequence s_addr_hit;
    (state_reg == input_limit_pkg::BUS_ADDR) && ev.fall && byte_done && addr_match
      && !ev.start && !ev.stop;
  endsequence

  property p_host_reset;
    @(posedge core_clk) $rose(reset_n) |-> host_limit_reg == `HOST_LIMIT_RESET;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("host limit reset wrong"); // R5

  property p_host_write;
    @(posedge core_clk) disable iff (!reset_n)
      s_host_word |=> host_limit_reg == {1'b0, $past(wr_word[14:8]), 8'h00};
  endproperty
  a_host_write: assert property (p_host_write) else $error("host write lost"); // R2

  property p_invalid_keep;
    @(posedge core_clk) disable iff (!reset_n)
      (host_write && wr_word[15] && !adapter_fall) |=> $stable(host_limit_reg) && invalid_write;
  endproperty
  a_invalid_keep: assert property (p_invalid_keep) else $error("invalid write took"); // R8

  property p_low_zero;
    @(posedge core_clk) disable iff (!reset_n)
      host_limit_reg[7:0] == 8'h00 && !host_limit_reg[15];
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("host reserved bits set"); // R9

  property p_adapter;
    @(posedge core_clk) disable iff (!reset_n)
      adapter_fall |=> host_limit_reg == `HOST_LIMIT_RESET;
  endproperty
  a_adapter: assert property (p_adapter) else $error("removal default missing"); // R6

  property p_optimizer;
    @(posedge core_clk) disable iff (!reset_n)
      optimizer_done |=> effective_limit_reg == {1'b0, $past(optimizer_code), 8'h00}
                         ##1 applied_limit_code == $past(optimizer_code, 2);
  endproperty
  a_optimizer: assert property (p_optimizer) else $error("optimizer limit lost"); // R13

  property p_decode;
    @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> applied_limit_ma == 13'($past(applied_limit_code)) * 13'h0032 + 13'h0032;
  endproperty
  a_decode: assert property (p_decode) else $error("limit decode wrong"); // R3

  property p_pin;
    @(posedge core_clk) disable iff (!reset_n)
      (pin_disable_reg || pin_hi_s) |=> !hw_limit_pin_enabled;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not disabled"); // R11

  property p_reduce;
    @(posedge core_clk) disable iff (!reset_n)
      (over_limit || vin_low_s) |=> reduce_charge;
  endproperty
  a_reduce: assert property (p_reduce) else $error("charge not reduced"); // R16

  property p_ack;
    @(posedge core_clk) disable iff (!reset_n)
      s_addr_hit |=> smb_data_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("address not acknowledged"); // R1

  property p_eff_layout;
    @(posedge core_clk) disable iff (!reset_n)
      effective_limit_reg[7:0] == 8'h00 && !effective_limit_reg[15];
  endproperty
  a_eff_layout: assert property (p_eff_layout) else $error("effective reserved bits set"); // R17

endmodule : input_current_limit_regs

// file: test/smbus_host_model.sv
// Purpose: Host controller model that drives the serial management bus.
// Assumes: Each bus phase lasts four core cycles; the data line has a pull-up.
// Notes:   The testbench calls its tasks.
`timescale 1ns/100ps
module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h09
) (
  input  wire logic core_clk,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask : hold
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    hold(4);
    scl = 1'b1;
    hold(4);
    s = sda_line;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask : bit_io
  task automatic start();
    sda_drv = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(4);
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b1;
    hold(8);
  endtask : stop
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_out
  task automatic byte_in(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask : byte_in
  // Whole word, low byte first.
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
                            output logic ack);
    logic [3:0] k;
    start();
    byte_out({a, 1'b0}, k[0]);
    byte_out(c, k[1]);
    byte_out(w[7:0], k[2]);
    byte_out(w[15:8], k[3]);
    stop();
    ack = &k;
  endtask : write_word
  task automatic read_word(input logic [7:0] c, output logic [15:0] w);
    logic k;
    start();
    byte_out({ADDR, 1'b0}, k);
    byte_out(c, k);
    start();
    byte_out({ADDR, 1'b1}, k);
    byte_in(1'b0, w[7:0]);
    byte_in(1'b1, w[15:8]);
    stop();
  endtask : read_word
endmodule : smbus_host_model

// file: test/input_current_limit_regs_test.sv
// Purpose: Self-checking bench for the input current limit bank.
// Assumes: Device address 7'h09.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/100ps
module input_current_limit_regs_test;
  logic        core_clk, reset_n, scl, sda_drv, adapter, pin4v, vin_low;
  logic        opt_done, inv_seen, ack, en, red, inv, oe;
  logic [12:0] cur_ma, ma;
  logic [6:0]  opt_code, code;
  logic [15:0] rd;
  logic [6:0]  codes [4] = '{7'h00, 7'h01, 7'h7F, 7'h2A};
  int          fail_count, total_checks;
  wire logic   dout;
  wire logic   sda_line = oe ? (sda_drv & dout) : sda_drv;
  smbus_host_model u_smbus_host_model (.core_clk(core_clk), .scl(scl), .sda_drv(sda_drv),
    .sda_line(sda_line));
  input_current_limit_regs u_input_current_limit_regs (.core_clk(core_clk), .reset_n(reset_n),
    .smb_clk_pin(scl), .smb_data_in(sda_line), .smb_data_out(dout), .smb_data_oe(oe),
    .adapter_present_pin(adapter), .hw_limit_pin_above_4v(pin4v),
    .vin_below_setting_pin(vin_low), .input_current_ma(cur_ma), .optimizer_done(opt_done),
    .optimizer_code(opt_code), .applied_limit_code(code), .applied_limit_ma(ma),
    .hw_limit_pin_enabled(en), .reduce_charge(red), .invalid_write(inv));
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (inv === 1'b1) inv_seen <= 1'b1;
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    u_smbus_host_model.write_word(7'h09, c, w, ack);
    check_flag(ack, 1'b1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    u_smbus_host_model.read_word(c, rd);
    check_word(rd, e);
  endtask : rd_chk
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask : settle
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    #2ms;
    fail_count++;
    final_report();
  end
  initial begin
    {reset_n, pin4v, vin_low, opt_done, inv_seen} = '0;
    {adapter, cur_ma, opt_code} = {1'b1, 13'h0000, 7'h00};
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    settle();
    rd_chk(8'h3F, 16'h4000);
    rd_chk(8'h22, 16'h0000);
    check_word({3'b0, ma}, 16'd3250);
    foreach (codes[i]) begin
      wr(8'h3F, {1'b0, codes[i], 8'hFF});
      rd_chk(8'h3F, {1'b0, codes[i], 8'h00});
      check_word({3'b0, ma}, {9'b0, codes[i]} * 16'd50 + 16'd50);
    end
    inv_seen = 1'b0;
    wr(8'h3F, 16'hC100);
    check_flag(inv_seen, 1'b1);
    rd_chk(8'h3F, 16'h2A00);
    wr(8'h22, 16'h1234);
    rd_chk(8'h22, 16'h2A00);
    u_smbus_host_model.write_word(7'h0A, 8'h3F, 16'h0100, ack);
    check_flag(ack, 1'b0);
    cur_ma = 13'd2150;
    settle();
    check_flag(red, 1'b0);
    cur_ma = 13'd2151;
    settle();
    check_flag(red, 1'b1);
    {cur_ma, vin_low} = {13'h0000, 1'b1};
    settle();
    check_flag(red, 1'b1);
    vin_low = 1'b0;
    settle();
    check_flag(en, 1'b1);
    pin4v = 1'b1;
    settle();
    check_flag(en, 1'b0);
    pin4v = 1'b0;
    wr(8'h31, 16'h0080);
    check_flag(en, 1'b0);
    rd_chk(8'h31, 16'h0080);
    {opt_code, opt_done} = {7'h15, 1'b1};
    @(negedge core_clk);
    opt_done = 1'b0;
    settle();
    check_word({9'b0, code}, 16'h0015);
    check_word({3'b0, ma}, 16'd1100);
    rd_chk(8'h22, 16'h1500);
    rd_chk(8'h3F, 16'h2A00);
    adapter = 1'b0;
    settle();
    rd_chk(8'h3F, 16'h4000);
    final_report();
  end
endmodule : input_current_limit_regs_test
